// ===== core/dcm_mode_config.sv
// Register bank and validity checks for special density calculation modes
// How it works
// - Mode none: standard equals compensated, share 100%
// - Modes 1-3: volume from calculated standard density
// - Net oil: share computed, volume from main portion
// - Mode 5: share computed, volume from main portion
// - Special mode accepted only with option present
// - Mode 7: share computed, volume from measured density
// - Modes act only when density source is 1
// - Petroleum modes: display shows standard density
// - Net oil crude density range check, bit 13
// - Net oil water density range check, bit 13
// - Mode 5 densities must differ over 10%
// - Substance densities used only in modes 4,5
// - Filter time constant register, default 2 s
// - Source value 1 means density from sensor
module dcm_mode_config
    import dcm_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic REG_SEL,
    input wire logic REG_WR,
    input wire logic [15:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    output logic [31:0] REG_RDATA,
    output logic REG_ACK,
    output logic REG_NAK,
    input wire logic SPECIAL_FUNC_PRESENT,
    input wire logic [31:0] DENSITY_SOURCE_CONFIG,
    input wire logic [31:0] COMPENSATED_DENSITY,
    input wire logic [31:0] CALC_STANDARD_DENSITY,
    input wire logic [31:0] CALC_MAIN_SHARE,
    output logic [31:0] STANDARD_DENSITY_RESULT,
    output logic [31:0] MAIN_SUBSTANCE_VOLUME_SHARE,
    output logic [2:0] ACTIVE_MODE,
    output logic [1:0] VOLUME_BASIS,
    output logic STANDARD_CALC_EN,
    output logic SHARE_CALC_EN,
    output logic SUBSTANCE_DENSITY_USE,
    output logic LOCAL_DISPLAY_STANDARD,
    output logic [31:0] DENSITY_FILTER_TAU,
    output logic [31:0] ERROR_FLAGS_WORD
);
    logic [2:0] special_density_mode_r;
    logic [31:0] main_substance_density_r;
    logic [31:0] added_substance_density_r;
    logic [31:0] density_filter_time_constant_r;
    logic opt_meta_r;
    logic opt_sync_r;
    logic [31:0] main_upper;
    logic [31:0] main_lower;
    logic [31:0] error_nxt;

    // Option pin comes from outside the clock domain
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            opt_meta_r <= 1'b0;
            opt_sync_r <= 1'b0;
        end
        else
        begin
            opt_meta_r <= SPECIAL_FUNC_PRESENT;
            opt_sync_r <= opt_meta_r;
        end
    end

    wire logic wr = REG_SEL && REG_WR;
    wire logic hit_mode = REG_ADDR == DCM_ADDR_MODE;
    wire logic hit_main = REG_ADDR == DCM_ADDR_MAIN;
    wire logic hit_add = REG_ADDR == DCM_ADDR_ADD;
    wire logic hit_tau = REG_ADDR == DCM_ADDR_TAU;
    wire logic hit_any = hit_mode || hit_main || hit_add || hit_tau;
    wire logic mode_code_ok = REG_WDATA[31:DCM_MODE_W] == '0;
    wire logic mode_special = REG_WDATA[2:0] == DCM_MODE_SPECIAL;
    wire logic mode_allowed = mode_code_ok && (!mode_special || opt_sync_r);
    wire logic wr_refused = wr && hit_mode && !mode_allowed;
    // One 32-bit word per register, no half-word access
    wire logic wr_mode = wr && hit_mode && mode_allowed;
    wire logic wr_main = wr && hit_main;
    wire logic wr_add = wr && hit_add;
    wire logic wr_tau = wr && hit_tau;
    wire logic rd_req = REG_SEL && !REG_WR;
    wire logic ack_nxt = REG_SEL && hit_any && !wr_refused;
    wire logic nak_nxt = REG_SEL && (!hit_any || wr_refused);
    wire logic [31:0] rd_mux =
        hit_mode ? {29'h0, special_density_mode_r} :
        hit_main ? main_substance_density_r :
        hit_add ? added_substance_density_r :
        hit_tau ? density_filter_time_constant_r : 32'h00000000;

    // Refused mode writes leave the old mode in force
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            special_density_mode_r <= DCM_RST_MODE[2:0];
        else if (wr_mode)
            special_density_mode_r <= REG_WDATA[2:0];
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            main_substance_density_r <= DCM_RST_MAIN;
        else if (wr_main)
            main_substance_density_r <= REG_WDATA;
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            added_substance_density_r <= DCM_RST_ADD;
        else if (wr_add)
            added_substance_density_r <= REG_WDATA;
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            density_filter_time_constant_r <= DCM_RST_TAU;
        else if (wr_tau)
            density_filter_time_constant_r <= REG_WDATA;
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            REG_RDATA <= 32'h00000000;
            REG_ACK <= 1'b0;
            REG_NAK <= 1'b0;
        end
        else
        begin
            REG_RDATA <= (rd_req && hit_any) ? rd_mux : 32'h00000000;
            REG_ACK <= ack_nxt;
            REG_NAK <= nak_nxt;
        end
    end

    // Ten percent band around the main density, one cycle of latency
    dcm_float_scale #(.FACTOR(DCM_K_UPPER)) u_upper
    (
        .clk(CLK),
        .rst(RST),
        .value_in(main_substance_density_r),
        .value_out(main_upper)
    );

    dcm_float_scale #(.FACTOR(DCM_K_LOWER)) u_lower
    (
        .clk(CLK),
        .rst(RST),
        .value_in(main_substance_density_r),
        .value_out(main_lower)
    );

    wire logic src_sensor = DENSITY_SOURCE_CONFIG == DCM_SRC_SENSOR;
    wire logic [2:0] eff_mode = src_sensor ? special_density_mode_r : DCM_MODE_NONE;
    wire logic is_petro = eff_mode == DCM_MODE_CRUDE || eff_mode == DCM_MODE_REFINED ||
        eff_mode == DCM_MODE_LUBE;
    wire logic is_net = eff_mode == DCM_MODE_NET_OIL;
    wire logic is_share = eff_mode == DCM_MODE_SHARE;
    wire logic is_share_meas = eff_mode == DCM_MODE_SHARE_MEAS;
    wire logic share_on = is_net || is_share || is_share_meas;
    wire logic [31:0] m = main_substance_density_r;
    wire logic [31:0] a = added_substance_density_r;

    // Sign bit set means negative, which fails every range; positive floats order as integers
    wire logic oil_bad = m[31] || m < DCM_OIL_MIN || m > DCM_OIL_MAX;
    wire logic water_bad = a[31] || a < DCM_WATER_MIN || a > DCM_WATER_MAX;
    wire logic near_main = a[31] || m[31] || (a <= main_upper && a >= main_lower);
    wire logic subst_bad = (is_net && (oil_bad || water_bad)) ||
        (is_share && near_main);

    // Flag position lives in the package so the host map has one home
    always_comb
    begin
        error_nxt = 32'h00000000;
        error_nxt[DCM_ERR_BIT] = subst_bad;
    end

    wire dcm_basis_t basis_nxt =
        is_petro ? DCM_BASIS_STANDARD :
        (is_net || is_share) ? DCM_BASIS_MAIN_PORTION :
        DCM_BASIS_MEASURED;

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            STANDARD_DENSITY_RESULT <= 32'h00000000;
            MAIN_SUBSTANCE_VOLUME_SHARE <= DCM_SHARE_FULL;
            ACTIVE_MODE <= DCM_MODE_NONE;
            VOLUME_BASIS <= DCM_BASIS_MEASURED;
            STANDARD_CALC_EN <= 1'b0;
            SHARE_CALC_EN <= 1'b0;
            SUBSTANCE_DENSITY_USE <= 1'b0;
            LOCAL_DISPLAY_STANDARD <= 1'b0;
            DENSITY_FILTER_TAU <= DCM_RST_TAU;
            ERROR_FLAGS_WORD <= 32'h00000000;
        end
        else
        begin
            STANDARD_DENSITY_RESULT <= (eff_mode == DCM_MODE_NONE) ?
                COMPENSATED_DENSITY : CALC_STANDARD_DENSITY;
            MAIN_SUBSTANCE_VOLUME_SHARE <= share_on ? CALC_MAIN_SHARE : DCM_SHARE_FULL;
            ACTIVE_MODE <= eff_mode;
            VOLUME_BASIS <= basis_nxt;
            STANDARD_CALC_EN <= is_petro;
            SHARE_CALC_EN <= share_on;
            SUBSTANCE_DENSITY_USE <= is_net || is_share;
            LOCAL_DISPLAY_STANDARD <= is_petro;
            DENSITY_FILTER_TAU <= density_filter_time_constant_r;
            // Level follows the live check, clears itself when values are valid
            ERROR_FLAGS_WORD <= error_nxt;
        end
    end
endmodule : dcm_mode_config

// ===== core/dcm_pkg.sv
// Constants and types for the density calculation mode configuration
package dcm_pkg;
    localparam logic [15:0] DCM_ADDR_MODE = 16'h683a;
    localparam logic [15:0] DCM_ADDR_MAIN = 16'h683c;
    localparam logic [15:0] DCM_ADDR_ADD = 16'h683e;
    localparam logic [15:0] DCM_ADDR_TAU = 16'h6848;

    localparam logic [2:0] DCM_MODE_NONE = 3'h0;
    localparam logic [2:0] DCM_MODE_CRUDE = 3'h1;
    localparam logic [2:0] DCM_MODE_REFINED = 3'h2;
    localparam logic [2:0] DCM_MODE_LUBE = 3'h3;
    localparam logic [2:0] DCM_MODE_NET_OIL = 3'h4;
    localparam logic [2:0] DCM_MODE_SHARE = 3'h5;
    localparam logic [2:0] DCM_MODE_SPECIAL = 3'h6;
    localparam logic [2:0] DCM_MODE_SHARE_MEAS = 3'h7;
    localparam int DCM_MODE_W = 3;

    localparam logic [31:0] DCM_SRC_SENSOR = 32'h00000001;

    // IEEE single precision, kg/m3, except the full share in percent
    localparam logic [31:0] DCM_OIL_MIN = 32'h4418a666;
    localparam logic [31:0] DCM_OIL_MAX = 32'h44917000;
    localparam logic [31:0] DCM_WATER_MIN = 32'h44794000;
    localparam logic [31:0] DCM_WATER_MAX = 32'h44a28000;
    localparam logic [31:0] DCM_SHARE_FULL = 32'h42c80000;

    // Scale factors as value times 2^23
    localparam logic [23:0] DCM_K_UPPER = 24'h8ccccd;
    localparam logic [23:0] DCM_K_LOWER = 24'h733333;

    localparam logic [31:0] DCM_RST_MODE = 32'h00000000;
    localparam logic [31:0] DCM_RST_MAIN = 32'h447a0000;
    localparam logic [31:0] DCM_RST_ADD = 32'h447a0000;
    localparam logic [31:0] DCM_RST_TAU = 32'h40000000;

    localparam int DCM_ERR_BIT = 13;

    typedef enum logic [1:0]
    {
        DCM_BASIS_MEASURED,
        DCM_BASIS_STANDARD,
        DCM_BASIS_MAIN_PORTION
    } dcm_basis_t;
endpackage : dcm_pkg

// ===== core/dcm_float_scale.sv
// Multiplies a positive single precision value by a fixed factor
module dcm_float_scale
    import dcm_pkg::*;
#(
    parameter logic [23:0] FACTOR = 24'h800000
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [31:0] value_in,
    output logic [31:0] value_out
);
    wire logic [23:0] mant = {1'b1, value_in[22:0]};
    wire logic [47:0] prod = 48'(mant) * 48'(FACTOR);
    wire logic [7:0] exp_in = value_in[30:23];
    logic [31:0] value_nxt;

    // Factor lies in [0.5, 2), so at most one step either way
    always_comb
    begin
        if (exp_in == 8'h00 || exp_in >= 8'hfe)
            value_nxt = {1'b0, exp_in, 23'h000000};
        else if (prod[47])
            value_nxt = {value_in[31], 8'(exp_in + 8'h01), prod[46:24]};
        else if (prod[46])
            value_nxt = {value_in[31], exp_in, prod[45:23]};
        else
            value_nxt = {value_in[31], 8'(exp_in - 8'h01), prod[44:22]};
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            value_out <= 32'h00000000;
        else
            value_out <= value_nxt;
    end
endmodule : dcm_float_scale

// ===== testbench/dcm_mode_config_chk.sv
// Port checker for the density mode configuration bank
module dcm_mode_config_chk
    import dcm_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic REG_SEL,
    input wire logic [15:0] REG_ADDR,
    input wire logic [31:0] REG_RDATA,
    input wire logic REG_ACK,
    input wire logic REG_NAK,
    input wire logic [31:0] DENSITY_SOURCE_CONFIG,
    input wire logic [31:0] MAIN_SUBSTANCE_VOLUME_SHARE,
    input wire logic [2:0] ACTIVE_MODE,
    input wire logic [1:0] VOLUME_BASIS,
    input wire logic STANDARD_CALC_EN,
    input wire logic SHARE_CALC_EN,
    input wire logic SUBSTANCE_DENSITY_USE,
    input wire logic LOCAL_DISPLAY_STANDARD,
    input wire logic [31:0] ERROR_FLAGS_WORD
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    wire logic mapped = REG_ADDR == DCM_ADDR_MODE || REG_ADDR == DCM_ADDR_MAIN ||
        REG_ADDR == DCM_ADDR_ADD || REG_ADDR == DCM_ADDR_TAU;
    wire logic petro = ACTIVE_MODE inside {DCM_MODE_CRUDE, DCM_MODE_REFINED, DCM_MODE_LUBE};
    wire logic subst = ACTIVE_MODE inside {DCM_MODE_NET_OIL, DCM_MODE_SHARE};
    AST_ANSWER_ONE: assert property (REG_SEL |=> REG_ACK != REG_NAK)
        else $error("Access not answered by exactly one of ack and nak");
    AST_IDLE_QUIET: assert property (
        !REG_SEL |=> !REG_ACK && !REG_NAK && REG_RDATA == 32'h0)
        else $error("Answer without an access");
    AST_UNMAPPED_NAK: assert property (
        REG_SEL && !mapped |=> REG_NAK && REG_RDATA == 32'h0)
        else $error("Unmapped access not refused");
    AST_SOURCE_GATE: assert property (
        DENSITY_SOURCE_CONFIG != DCM_SRC_SENSOR |=> ACTIVE_MODE == 3'h0)
        else $error("Mode active without sensor density source");
    AST_SHARE_FULL: assert property (
        (!SHARE_CALC_EN) [*2] |-> MAIN_SUBSTANCE_VOLUME_SHARE == DCM_SHARE_FULL)
        else $error("Share not full outside share modes");
    AST_PETRO_PATH: assert property (
        petro |-> STANDARD_CALC_EN && LOCAL_DISPLAY_STANDARD &&
        VOLUME_BASIS == DCM_BASIS_STANDARD)
        else $error("Petroleum mode outputs wrong");
    AST_MAIN_PORTION: assert property (
        subst |-> SUBSTANCE_DENSITY_USE && SHARE_CALC_EN &&
        VOLUME_BASIS == DCM_BASIS_MAIN_PORTION)
        else $error("Substance mode outputs wrong");
    AST_MEASURED_SHARE: assert property (
        ACTIVE_MODE == DCM_MODE_SHARE_MEAS |-> SHARE_CALC_EN && !SUBSTANCE_DENSITY_USE &&
        VOLUME_BASIS == DCM_BASIS_MEASURED)
        else $error("Measured share mode outputs wrong");
    AST_ERR_BIT_ONLY: assert property (
        ERROR_FLAGS_WORD[31:14] == 18'h0 && ERROR_FLAGS_WORD[12:0] == 13'h0)
        else $error("Error word has a bit other than 13");
    AST_ERR_IDLE: assert property (
        (!SUBSTANCE_DENSITY_USE) [*3] |-> !ERROR_FLAGS_WORD[DCM_ERR_BIT])
        else $error("Density error outside substance modes");
endmodule : dcm_mode_config_chk

bind dcm_mode_config dcm_mode_config_chk chk (.*);

// ===== testbench/dcm_mode_config_test.sv
// Self-checking bench for the density mode configuration bank
module dcm_mode_config_test
    import dcm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK = 1'b0, RST = 1'b1, REG_SEL = 1'b0, REG_WR = 1'b0, SPECIAL_FUNC_PRESENT = 1'b0;
    logic [15:0] REG_ADDR = 16'h0;
    logic [31:0] REG_WDATA = 32'h0, DENSITY_SOURCE_CONFIG = 32'h1;
    logic [31:0] COMPENSATED_DENSITY = 32'h44700000;
    logic [31:0] CALC_STANDARD_DENSITY = 32'h44610000, CALC_MAIN_SHARE = 32'h42a00000;
    logic [31:0] REG_RDATA, STANDARD_DENSITY_RESULT, MAIN_SUBSTANCE_VOLUME_SHARE;
    logic [31:0] DENSITY_FILTER_TAU, ERROR_FLAGS_WORD, rd;
    logic REG_ACK, REG_NAK, STANDARD_CALC_EN, SHARE_CALC_EN, SUBSTANCE_DENSITY_USE;
    logic LOCAL_DISPLAY_STANDARD;
    logic [2:0] ACTIVE_MODE;
    logic [1:0] VOLUME_BASIS;
    int fail_count = 0, checks_done = 0;

    always #10 CLK = ~CLK;

    dcm_mode_config dut (.*);

    task test_done;
        $display("Checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // One access; answer is registered on the taking edge, so look 1 ns after that edge
    task acc(input logic wr, input logic [15:0] a, input logic [31:0] d, input logic nak);
        @(posedge CLK);
        REG_SEL <= 1'b1;
        REG_WR <= wr;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge CLK);
        REG_SEL <= 1'b0;
        #1;
        chk("ack", {31'h0, REG_ACK}, {31'h0, !nak});
        chk("nak", {31'h0, REG_NAK}, {31'h0, nak});
        rd = REG_RDATA;
    endtask : acc

    task wait_n(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask : wait_n

    task t_reset;
        acc(1'b0, DCM_ADDR_MODE, 32'h0, 1'b0);
        chk("mode", rd, DCM_RST_MODE);
        acc(1'b0, DCM_ADDR_MAIN, 32'h0, 1'b0);
        chk("main", rd, DCM_RST_MAIN);
        acc(1'b0, DCM_ADDR_TAU, 32'h0, 1'b0);
        chk("tau", rd, 32'h40000000);
        chk("tau out", DENSITY_FILTER_TAU, 32'h40000000);
        acc(1'b0, 16'h683b, 32'h0, 1'b1);
        chk("unmapped", rd, 32'h0);
        acc(1'b1, DCM_ADDR_TAU, 32'h41200000, 1'b0);
        acc(1'b0, DCM_ADDR_TAU, 32'h0, 1'b0);
        chk("tau wr", rd, 32'h41200000);
        chk("tau out wr", DENSITY_FILTER_TAU, 32'h41200000);
    endtask : t_reset

    task t_modes;
        for (int m = 1; m < 8; m++)
        begin
            if (m == 6)
                continue;
            acc(1'b1, DCM_ADDR_MODE, 32'(m), 1'b0);
            wait_n(2);
            chk("active", 32'(ACTIVE_MODE), 32'(m));
            chk("std en", 32'(STANDARD_CALC_EN), 32'(m <= 3));
            chk("display", 32'(LOCAL_DISPLAY_STANDARD), 32'(m <= 3));
            chk("basis", 32'(VOLUME_BASIS),
                m <= 3 ? 32'h1 : m <= 5 ? 32'h2 : 32'h0);
            chk("share", MAIN_SUBSTANCE_VOLUME_SHARE,
                m >= 4 ? CALC_MAIN_SHARE : DCM_SHARE_FULL);
            chk("share en", 32'(SHARE_CALC_EN), 32'(m >= 4));
            chk("subst use", 32'(SUBSTANCE_DENSITY_USE), 32'(m == 4 || m == 5));
            chk("std", STANDARD_DENSITY_RESULT, CALC_STANDARD_DENSITY);
        end
        @(posedge CLK);
        DENSITY_SOURCE_CONFIG <= 32'h2;
        wait_n(3);
        chk("gated", 32'(ACTIVE_MODE), 32'h0);
        chk("gated std", STANDARD_DENSITY_RESULT, COMPENSATED_DENSITY);
        @(posedge CLK);
        DENSITY_SOURCE_CONFIG <= 32'h1;
        acc(1'b1, DCM_ADDR_MODE, 32'h0, 1'b0);
        wait_n(3);
        chk("std none", STANDARD_DENSITY_RESULT, COMPENSATED_DENSITY);
        chk("share none", MAIN_SUBSTANCE_VOLUME_SHARE, DCM_SHARE_FULL);
    endtask : t_modes

    // Option pin is synchronised, so allow settling before retry
    task t_special;
        acc(1'b1, DCM_ADDR_MODE, 32'h6, 1'b1);
        acc(1'b1, DCM_ADDR_MODE, 32'h9, 1'b1);
        acc(1'b0, DCM_ADDR_MODE, 32'h0, 1'b0);
        chk("kept", rd, 32'h0);
        @(posedge CLK);
        SPECIAL_FUNC_PRESENT <= 1'b1;
        wait_n(3);
        acc(1'b1, DCM_ADDR_MODE, 32'h6, 1'b0);
        wait_n(2);
        chk("special", 32'(ACTIVE_MODE), 32'h6);
    endtask : t_special

    task err_case(input logic [31:0] m, input logic [31:0] mn, input logic [31:0] ad,
        input logic e);
        acc(1'b1, DCM_ADDR_MODE, m, 1'b0);
        acc(1'b1, DCM_ADDR_MAIN, mn, 1'b0);
        acc(1'b1, DCM_ADDR_ADD, ad, 1'b0);
        wait_n(4);
        chk("error", ERROR_FLAGS_WORD, {18'h0, e, 13'h0});
    endtask : err_case

    task t_errors;
        err_case(32'h4, 32'h43fa0000, 32'h447a0000, 1'b1);
        err_case(32'h4, 32'h44480000, 32'h447a0000, 1'b0);
        err_case(32'h4, 32'h44480000, 32'h44af0000, 1'b1);
        err_case(32'h5, 32'h447a0000, 32'h44834000, 1'b1);
        err_case(32'h5, 32'h447a0000, 32'h44960000, 1'b0);
        err_case(32'h0, 32'h43fa0000, 32'h44af0000, 1'b0);
    endtask : t_errors

    initial
    begin
        repeat (6) @(posedge CLK);
        RST <= 1'b0;
        t_reset;
        t_modes;
        t_special;
        t_errors;
        test_done;
    end

    // Whole run is about 130 cycles; generous margin
    initial
    begin
        repeat (5000) @(posedge CLK);
        fail_count++;
        test_done;
    end
endmodule : dcm_mode_config_test
